// [src/acf_consts.svh]
// Purpose: offsets, field positions, reset values and codes of the result formatter
// Assumes: included by bare name from every design file that needs a constant
// Notes:   definitions only
`ifndef ACF_CONSTS_SVH
`define ACF_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets on the apb
// ----------------------------------------------------------------
`define ACF_OFS_SEL    8'h00
`define ACF_OFS_RES_LO 8'h04
`define ACF_OFS_RES_HI 8'h08
`define ACF_OFS_CTRL_B 8'h0C
`define ACF_OFS_MISC   8'h10
`define ACF_OFS_STAT   8'h14
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define ACF_SEL_RST    8'h00
`define ACF_REFS_HI    7
`define ACF_REFS_LO    6
`define ACF_LADJ_BIT   5
`define ACF_CH_MSB     4
`define ACF_BIN_BIT    0
`define ACF_AREF_BIT   0
`define ACF_REFERENCE_OUTPUT_PIN_BIT   1
`define ACF_DONE_BIT   0
`define ACF_CH_TEMP    5'h0B
`define ACF_CODE_ZERO  10'h000
`define ACF_CODE_MAX   10'h3FF
`define ACF_PAD6       6'h00
`define ACF_RD_ZERO    32'h0000_0000
`endif

// [src/acf_pkg.sv]
// Purpose: types shared by the result formatter files
// Assumes: nothing
// Notes:   constants live in acf_consts.svh
package acf_pkg;
  // conversion kind derived from channel field and bipolar select
  typedef enum logic [1:0] {
    ACF_SINGLE   = 2'h0,
    ACF_UNIPOLAR = 2'h1,
    ACF_BIPOLAR  = 2'h3
  } acf_mode_e;
  // converter reference source
  typedef enum logic [1:0] {
    ACF_REF_SUPPLY = 2'h0,
    ACF_REF_EXTPIN = 2'h1,
    ACF_REF_INT1V1 = 2'h3,
    ACF_REF_INT2V5 = 2'h2
  } acf_ref_e;
endpackage

// [src/acf_fmt.sv]
// Purpose: turns the raw signed conversion figure into the 10-bit result code
// Assumes: raw is already saturated to 11-bit signed by the analog side
// Notes:   pure combinational, registered by the top
`timescale 1ns/1ps
`include "acf_consts.svh"
module acf_fmt (
  // mode and raw figure
  input  wire acf_pkg::acf_mode_e mode,
  input  wire logic [10:0]        conv_raw,
  // formatted code
  output logic [9:0]              code
);
  import acf_pkg::*;
  // ----------------------------------------------------------------
  // code selection
  // ----------------------------------------------------------------
  // negative raw clamps to zero outside bipolar; halving gives the 512 scale
  wire       raw_neg   = conv_raw[10];
  wire [9:0] uni_code  = raw_neg ? `ACF_CODE_ZERO : conv_raw[9:0];
  wire [9:0] bip_code  = conv_raw[10:1];
  assign code = (mode == ACF_BIPOLAR) ? bip_code : uni_code;
endmodule

// [src/acf_refsel.sv]
// Purpose: holds the selection the converter really uses and drives the reference pin
// Assumes: conv_busy and conv_done come from conversion timing on the same clock
// Notes:   software copy may change freely; this copy follows only at safe points
`timescale 1ns/1ps
`include "acf_consts.svh"
module acf_refsel (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // software view
  input  wire logic [7:0]       sw_sel,
  input  wire logic             sw_aref_en,
  input  wire logic             sw_reference_output_pin_en,
  // converter status
  input  wire logic             conv_enable,
  input  wire logic             conv_busy,
  input  wire logic             conv_done,
  // active selection
  output logic [4:0]            act_channel_ff,
  output logic                  act_diff_ff,
  output logic                  act_gain20_ff,
  output logic                  temp_sensor_en_ff,
  output acf_pkg::acf_ref_e     ref_src_ff,
  // reference output pin
  output logic                  ref_out_level_ff,
  output logic                  ref_out_oe_n_ff
);
  import acf_pkg::*;
  // ----------------------------------------------------------------
  // decode of the software copy
  // ----------------------------------------------------------------
  // follow while idle and again in the completion cycle, so a mid-conversion
  // change cannot disturb the sample under way
  wire       load    = ~conv_busy | conv_done;
  wire [4:0] sw_ch   = sw_sel[`ACF_CH_MSB:0];
  wire       refs_hi = sw_sel[`ACF_REFS_HI];
  wire       refs_lo = sw_sel[`ACF_REFS_LO];
  // external enable wins only while the low select bit is clear
  wire acf_ref_e nxt_ref = ~refs_lo ? (sw_aref_en ? ACF_REF_EXTPIN : ACF_REF_SUPPLY)
                         : (refs_hi ? ACF_REF_INT2V5 : ACF_REF_INT1V1);
  // pin drives only for 01 or 11 with the converter on
  wire       nxt_drv = sw_reference_output_pin_en & conv_enable & refs_lo;
  // ----------------------------------------------------------------
  // active selection registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_channel_ff    <= 5'h00;
      act_diff_ff       <= 1'b0;
      act_gain20_ff     <= 1'b0;
      temp_sensor_en_ff <= 1'b0;
      ref_src_ff        <= ACF_REF_SUPPLY;
      ref_out_level_ff  <= 1'b0;
      ref_out_oe_n_ff   <= 1'b1;
    end else begin
      if (load) begin
        act_channel_ff    <= sw_ch;
        act_diff_ff       <= sw_ch[`ACF_CH_MSB];
        act_gain20_ff     <= sw_ch[`ACF_CH_MSB] & sw_ch[0];
        temp_sensor_en_ff <= (sw_ch == `ACF_CH_TEMP);
        ref_src_ff        <= nxt_ref;
      end
      ref_out_oe_n_ff  <= ~nxt_drv;
      ref_out_level_ff <= refs_hi;                                 // high selects 2.56V
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sel_locked_busy: assert property (@(posedge pclk) disable iff (!presetn)
    conv_busy && !conv_done |=> $stable(act_channel_ff) && $stable(ref_src_ff))
    else $error("active selection moved during a conversion");
  a_ref_pin_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    !sw_reference_output_pin_en || !conv_enable |=> ref_out_oe_n_ff)
    else $error("reference pin driven while disabled");
  a_gain_select: assert property (@(posedge pclk) disable iff (!presetn)
    act_gain20_ff |-> act_diff_ff && act_channel_ff[0])
    else $error("gain setting does not match channel field");
endmodule

// [src/acf_top.sv]
// Purpose: apb slave for channel/reference select and formatted 10-bit results
// Assumes: conv_done is a one-cycle pulse with conv_raw valid, all on pclk
// Notes:   each apb access takes one wait state; outputs come from flip-flops
//
// Functional notes
// - result bytes hold the finished code by the time the done flag rises.
// - single-ended code is vin*1024/vref, ground 0x000, top 0x3FF.
// - unipolar differential scales by 1024*gain/vref and clamps negatives to zero.
// - differential channels use gain 8x or 20x from the channel field.
// - differential runs unipolar after reset; bipolar only after software sets it.
// - bipolar code scales by 512, two's complement 0x200 to 0x1FF.
// - in bipolar results code bit 9 is the sign: top bit of the high byte left-adjusted, bit 1 right-adjusted.
// - reference pin floats unless enabled, converter on and select 01 or 11; 01 1.1V, 11 2.56V.
// - select register 8 bits read-write, reset zero, fields 7:6, 5, 4:0.
// - left-adjust bit changes result byte layout at once, even mid-conversion.
// - reference choice from select and external enable; changes wait for completion.
`timescale 1ns/1ps
`include "acf_consts.svh"
module acf_top (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata_ff,
  output logic                  pready_ff,
  output logic                  pslverr_ff,
  // conversion side
  input  wire logic             conv_enable,
  input  wire logic             conv_busy,
  input  wire logic             conv_done,
  input  wire logic [10:0]      conv_raw,
  // selection towards the analog front end
  output logic [4:0]            act_channel_ff,
  output logic                  act_diff_ff,
  output logic                  act_gain20_ff,
  output logic                  temp_sensor_en_ff,
  output acf_pkg::acf_ref_e     ref_src_ff,
  output acf_pkg::acf_mode_e    mode_ff,
  // reference output pin
  output logic                  ref_out_level_ff,
  output logic                  ref_out_oe_n_ff,
  // completion
  output logic                  conversion_done_flag_ff
);
  import acf_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] sel_ff;
  logic       bin_ff;
  logic       aref_en_ff;
  logic       reference_output_pin_en_ff;
  logic [9:0] result_ff;
  logic [9:0] fmt_code;

  // ----------------------------------------------------------------
  // apb phase decode
  // ----------------------------------------------------------------
  // first access cycle prepares the answer; the second one commits it
  wire acc_first = psel & penable & ~pready_ff;
  wire commit    = psel & penable & pready_ff;
  wire hit_sel   = (paddr == `ACF_OFS_SEL);
  wire hit_lo    = (paddr == `ACF_OFS_RES_LO);
  wire hit_hi    = (paddr == `ACF_OFS_RES_HI);
  wire hit_ctrl  = (paddr == `ACF_OFS_CTRL_B);
  wire hit_misc  = (paddr == `ACF_OFS_MISC);
  wire hit_stat  = (paddr == `ACF_OFS_STAT);
  wire hit_any   = hit_sel | hit_lo | hit_hi | hit_ctrl | hit_misc | hit_stat;
  // result bytes are read-only; writes there are dropped without error
  wire wr_sel    = commit & pwrite & hit_sel;
  wire wr_ctrl   = commit & pwrite & hit_ctrl;
  wire wr_misc   = commit & pwrite & hit_misc;
  wire clr_done  = commit & pwrite & hit_stat & pwdata[`ACF_DONE_BIT];

  // ----------------------------------------------------------------
  // result byte layout
  // ----------------------------------------------------------------
  // layout is picked at read time from the live bit, so a change shows at once
  wire       ladj    = sel_ff[`ACF_LADJ_BIT];
  wire [7:0] res_lo  = ladj ? {result_ff[1:0], `ACF_PAD6} : result_ff[7:0];
  wire [7:0] res_hi  = ladj ? result_ff[9:2] : {`ACF_PAD6, result_ff[9:8]};

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_sel  = {24'h000000, sel_ff};
  wire [31:0] rd_lo   = {24'h000000, res_lo};
  wire [31:0] rd_hi   = {24'h000000, res_hi};
  wire [31:0] rd_ctrl = {31'h00000000, bin_ff};
  wire [31:0] rd_misc = {30'h00000000, reference_output_pin_en_ff, aref_en_ff};
  wire [31:0] rd_stat = {31'h00000000, conversion_done_flag_ff};
  wire [31:0] rd_mux  = hit_sel  ? rd_sel  :
                        hit_lo   ? rd_lo   :
                        hit_hi   ? rd_hi   :
                        hit_ctrl ? rd_ctrl :
                        hit_misc ? rd_misc :
                        hit_stat ? rd_stat : `ACF_RD_ZERO;

  // ----------------------------------------------------------------
  // conversion kind
  // ----------------------------------------------------------------
  // bipolar select only matters for differential channels
  wire acf_mode_e nxt_mode = ~act_diff_ff ? ACF_SINGLE :
                             (bin_ff ? ACF_BIPOLAR : ACF_UNIPOLAR);

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // one wait state keeps prdata and pslverr straight from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= `ACF_RD_ZERO;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= acc_first;
      prdata_ff  <= (acc_first & ~pwrite) ? rd_mux : `ACF_RD_ZERO;
      pslverr_ff <= acc_first & ~hit_any;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff     <= `ACF_SEL_RST;
      bin_ff     <= 1'b0;
      aref_en_ff <= 1'b0;
      reference_output_pin_en_ff <= 1'b0;
    end else begin
      if (wr_sel) begin
        sel_ff <= pwdata[7:0];
      end
      if (wr_ctrl) begin
        bin_ff <= pwdata[`ACF_BIN_BIT];
      end
      if (wr_misc) begin
        aref_en_ff <= pwdata[`ACF_AREF_BIT];
        reference_output_pin_en_ff <= pwdata[`ACF_REFERENCE_OUTPUT_PIN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // result capture and completion flag
  // ----------------------------------------------------------------
  // one 10-bit word holds the code so both bytes come from one sample unless a completion lands between the two reads;
  // the flag rises on the same edge, and a new completion beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff               <= `ACF_CODE_ZERO;
      conversion_done_flag_ff <= 1'b0;
      mode_ff                 <= ACF_SINGLE;
    end else begin
      mode_ff <= nxt_mode;
      if (conv_done) begin
        result_ff <= fmt_code;
      end
      conversion_done_flag_ff <= conv_done | (conversion_done_flag_ff & ~clr_done);
    end
  end

  // ----------------------------------------------------------------
  // formatter and selection
  // ----------------------------------------------------------------
  acf_fmt u_fmt (
    .mode     (nxt_mode),
    .conv_raw (conv_raw),
    .code     (fmt_code)
  );

  acf_refsel u_refsel (
    .pclk              (pclk),
    .presetn           (presetn),
    .sw_sel            (sel_ff),
    .sw_aref_en        (aref_en_ff),
    .sw_reference_output_pin_en        (reference_output_pin_en_ff),
    .conv_enable       (conv_enable),
    .conv_busy         (conv_busy),
    .conv_done         (conv_done),
    .act_channel_ff    (act_channel_ff),
    .act_diff_ff       (act_diff_ff),
    .act_gain20_ff     (act_gain20_ff),
    .temp_sensor_en_ff (temp_sensor_en_ff),
    .ref_src_ff        (ref_src_ff),
    .ref_out_level_ff  (ref_out_level_ff),
    .ref_out_oe_n_ff   (ref_out_oe_n_ff)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_result_with_flag: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> conversion_done_flag_ff && result_ff == $past(fmt_code))
    else $error("result not in place when done flag rose");

  a_single_code: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && nxt_mode == ACF_SINGLE && !conv_raw[10]
    |=> result_ff == $past(conv_raw[9:0]))
    else $error("single-ended code differs from raw figure");

  a_unipolar_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && nxt_mode == ACF_UNIPOLAR && conv_raw[10]
    |=> result_ff == `ACF_CODE_ZERO)
    else $error("negative unipolar difference not clamped");

  a_bipolar_scale: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && nxt_mode == ACF_BIPOLAR |=> result_ff == $past(conv_raw[10:1]))
    else $error("bipolar code not half-scaled two's complement");

  a_bipolar_sign: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && nxt_mode == ACF_BIPOLAR |=> result_ff[9] == $past(conv_raw[10]))
    else $error("bipolar sign bit wrong");

  a_bin_write_only: assert property (@(posedge pclk) disable iff (!presetn)
    !$stable(bin_ff) |-> $past(wr_ctrl))
    else $error("bipolar select moved without a write");

  a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_sel |=> sel_ff == $past(pwdata[7:0]))
    else $error("select register did not take write data");

  a_left_adjust_read: assert property (@(posedge pclk) disable iff (!presetn)
    acc_first && !pwrite && hit_hi && ladj |=> prdata_ff[7:0] == $past(result_ff[9:2]))
    else $error("left-adjusted high byte wrong");

  a_result_only_done: assert property (@(posedge pclk) disable iff (!presetn)
    !$stable(result_ff) |-> $past(conv_done))
    else $error("result changed outside a completion");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not after exactly one wait state");

  // ----------------------------------------------------------------
  // read path, flag, code, select hold, mode and apb ready checks
  // ----------------------------------------------------------------
  // a completion in the clearing cycle must survive, or software misses a result
  a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && clr_done |=> conversion_done_flag_ff)
    else $error("completion lost to a clear");

  a_flag_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    clr_done && !conv_done |=> !conversion_done_flag_ff)
    else $error("done flag survived a clear");

  a_unipolar_code: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && nxt_mode == ACF_UNIPOLAR && !conv_raw[10]
    |=> result_ff == $past(conv_raw[9:0]))
    else $error("unipolar code differs from raw figure");

  a_single_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done && nxt_mode == ACF_SINGLE && conv_raw[10] |=> result_ff == `ACF_CODE_ZERO)
    else $error("negative single-ended figure not clamped");

  a_right_adjust_lo: assert property (@(posedge pclk) disable iff (!presetn)
    acc_first && !pwrite && hit_lo && !ladj |=> prdata_ff[7:0] == $past(result_ff[7:0]))
    else $error("right-adjusted low byte wrong");

  a_left_adjust_lo: assert property (@(posedge pclk) disable iff (!presetn)
    acc_first && !pwrite && hit_lo && ladj |=> prdata_ff[7:0] == {$past(result_ff[1:0]), `ACF_PAD6})
    else $error("left-adjusted low byte wrong");

  a_right_adjust_hi: assert property (@(posedge pclk) disable iff (!presetn)
    acc_first && !pwrite && hit_hi && !ladj |=> prdata_ff[7:0] == {`ACF_PAD6, $past(result_ff[9:8])})
    else $error("right-adjusted high byte wrong");

  a_upper_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready_ff |-> prdata_ff[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  a_sel_read: assert property (@(posedge pclk) disable iff (!presetn)
    acc_first && !pwrite && hit_sel |=> prdata_ff[7:0] == $past(sel_ff))
    else $error("select register read wrong");

  a_sel_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_sel |=> $stable(sel_ff))
    else $error("select register moved without a write");

  a_mode_unipolar: assert property (@(posedge pclk) disable iff (!presetn)
    act_diff_ff && !bin_ff |=> mode_ff == ACF_UNIPOLAR)
    else $error("differential not unipolar while bipolar clear");

  a_mode_bipolar: assert property (@(posedge pclk) disable iff (!presetn)
    act_diff_ff && bin_ff |=> mode_ff == ACF_BIPOLAR)
    else $error("differential not bipolar while bipolar set");

  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    acc_first && !hit_any |=> pslverr_ff && prdata_ff == `ACF_RD_ZERO)
    else $error("unmapped access not refused");

  a_write_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    acc_first && pwrite |=> prdata_ff == `ACF_RD_ZERO)
    else $error("read data shown on a write");

  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready_ff |=> !pready_ff)
    else $error("ready held longer than one cycle");
endmodule

// [bench/acf_analog_model.sv]
// Purpose: analog front end and conversion timing beside the result formatter
// Assumes: the bench hands over raw figures already scaled to lsb
// Notes:   the raw figure is valid only in the done cycle
`timescale 1ns/1ps
module acf_analog_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // commands from the bench
  input  wire logic        start,
  input  wire logic [10:0] raw_in,
  input  wire logic [3:0]  busy_len,
  // converter side
  output logic             busy_ff,
  output logic             done_ff,
  output logic [10:0]      raw_ff
);
  logic [3:0] cnt_ff;
  // busy for busy_len+1 cycles, then one done pulse carrying the figure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      raw_ff  <= 11'h000;
    end else begin
      done_ff <= 1'b0;
      raw_ff  <= ~raw_ff; // a stale figure must never pass for a fresh one
      if (start) begin
        busy_ff <= 1'b1;
        cnt_ff  <= busy_len;
      end else if (busy_ff && cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
        raw_ff  <= raw_in; // difference saturated on the analog side
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule

// [bench/testbench.sv]
// Purpose: register and result checks of the formatter over apb
// Assumes: one wait state per access, answer awaited under a bound
// Notes:   expected codes are worked out here, never read back from the design
`timescale 1ns/1ps
`include "acf_consts.svh"
module testbench;
  import acf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, prdy, perr, conv_enable, start, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        conv_busy, conv_done, diff, gain20, temp_en, lvl, oe_n, flag;
  logic [10:0] conv_raw, raw_in;
  logic [3:0]  busy_len;
  logic [4:0]  chan;
  acf_ref_e    rsrc;
  acf_mode_e   mode;
  int          bad_count, checks_done, cycles;
  // ------------------------------------------------------------
  // design and analog partner
  // ------------------------------------------------------------
  acf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata), .pready_ff(prdy), .pslverr_ff(perr),
    .conv_enable(conv_enable), .conv_busy(conv_busy), .conv_done(conv_done), .conv_raw(conv_raw),
    .act_channel_ff(chan), .act_diff_ff(diff), .act_gain20_ff(gain20), .temp_sensor_en_ff(temp_en),
    .ref_src_ff(rsrc), .mode_ff(mode), .ref_out_level_ff(lvl), .ref_out_oe_n_ff(oe_n),
    .conversion_done_flag_ff(flag));
  acf_analog_model afe (.pclk(pclk), .presetn(presetn), .start(start), .raw_in(raw_in),
    .busy_len(busy_len), .busy_ff(conv_busy), .done_ff(conv_done), .raw_ff(conv_raw));
  // ------------------------------------------------------------
  // clock, timeout and closing report
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; released once pready is sampled high or after 20 cycles
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rd  = prdata;
    err = perr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("apb answer", 1, n < 20);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, exp, rd);
  endtask
  // expected {high, low} bytes of a finished figure
  function automatic logic [15:0] exp_res(input logic [10:0] raw, input logic bip, input logic ladj);
    logic [9:0] c;
    c = bip ? raw[10:1] : (raw[10] ? `ACF_CODE_ZERO : raw[9:0]);
    return ladj ? {c, 6'h00} : {6'h00, c};
  endfunction
  task automatic res(input logic [15:0] e);
    rdchk("result low", `ACF_OFS_RES_LO, {24'h000000, e[7:0]});
    rdchk("result high", `ACF_OFS_RES_HI, {24'h000000, e[15:8]});
  endtask
  // flag is cleared first so that its rise proves this conversion
  task automatic conv_go(input logic [10:0] raw, input logic [3:0] len);
    apb(1'b1, `ACF_OFS_STAT, 32'h0000_0001);
    @(posedge pclk);
    raw_in   <= raw;
    busy_len <= len;
    start    <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
  endtask
  task automatic conv_end();
    int n = 0;
    while (flag !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check("done flag", 1, flag);
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [10:0] se[4];
    se = '{11'h3FF, 11'h000, 11'h7FF, 11'h155};
    {presetn, psel, penable, pwrite, conv_enable, start} = 6'h00;
    {paddr, pwdata, raw_in, busy_len} = 55'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check("pin enable at reset", 1, oe_n);
    check("mode at reset", ACF_SINGLE, mode);
    rdchk("select reset", `ACF_OFS_SEL, 32'h0000_0000);
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_00FF);
    rdchk("select rw", `ACF_OFS_SEL, 32'h0000_00FF);
    apb(1'b0, 8'h18, 32'h0000_0000);
    check("unmapped error", 1, err);
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_0000);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      conv_go(se[i], 4'h2);
      conv_end();
      res(exp_res(se[i], 1'b0, 1'b0));
    end
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_0020);
    res(exp_res(se[3], 1'b0, 1'b1));
    $display("test single ended done");
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_0010);
    settle();
    check("diff gain 8", 32'h0000_0001, {gain20, diff});
    check("unipolar", ACF_UNIPOLAR, mode);
    conv_go(11'h700, 4'h1);
    conv_end();
    res(16'h0000);
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_0011);
    settle();
    check("diff gain 20", 32'h0000_0003, {gain20, diff});
    conv_go(11'h2A5, 4'h1);
    conv_end();
    res(exp_res(11'h2A5, 1'b0, 1'b0));
    apb(1'b1, `ACF_OFS_CTRL_B, 32'h0000_0001);
    settle();
    check("bipolar", ACF_BIPOLAR, mode);
    conv_go(11'h400, 4'h1);
    conv_end();
    res(exp_res(11'h400, 1'b1, 1'b0));
    check("sign bit", 1, rd[1]);
    conv_go(11'h3FE, 4'h1);
    conv_end();
    res(exp_res(11'h3FE, 1'b1, 1'b0));
    check("sign bit", 0, rd[1]);
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_0031);
    res(exp_res(11'h3FE, 1'b1, 1'b1));
    apb(1'b1, `ACF_OFS_CTRL_B, 32'h0000_0000);
    $display("test differential done");
    // converter on, then the reference pin output enabled with external enable clear
    conv_enable <= 1'b1;
    apb(1'b1, `ACF_OFS_MISC, 32'h0000_0002);
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_004B);
    settle();
    check("pin 1v1", 32'h0000_0000, {oe_n, lvl});
    check("temp sensor", 1, temp_en);
    check("ref 1v1", ACF_REF_INT1V1, rsrc);
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_00CB);
    settle();
    check("pin 2v56", 32'h0000_0001, {oe_n, lvl});
    check("ref 2v56", ACF_REF_INT2V5, rsrc);
    conv_enable <= 1'b0;
    settle();
    check("pin off", 1, oe_n);
    apb(1'b1, `ACF_OFS_MISC, 32'h0000_0001);
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_0000);
    settle();
    check("ref ext", ACF_REF_EXTPIN, rsrc);
    conv_go(11'h0AA, 4'hF);
    apb(1'b1, `ACF_OFS_SEL, 32'h0000_0005);
    settle();
    check("locked channel", 0, chan);
    conv_end();
    settle();
    check("new channel", 5, chan);
    $display("test reference done");
    end_of_test();
  end
endmodule
